// File: hdl/flash_host_pkg.sv
// Constants and types for the NAND flash host sequencer
package flash_host_pkg;

    // Clock and timing
    localparam int          CLK_MHZ        = 20;
    localparam int          CLK_NS         = 1000 / CLK_MHZ;
    localparam int          T_BYTE_NS      = 25;
    localparam int          T_READ_US      = 60;
    localparam int          T_PROG_US      = 800;
    localparam int          T_ERASE_US     = 2500;
    localparam int          T_WB_NS        = 100;
    localparam int          BYTE_CYC       = 2;
    localparam int          READ_CYC       = T_READ_US * CLK_MHZ;
    localparam int          PROG_CYC       = T_PROG_US * CLK_MHZ;
    localparam int          ERASE_CYC      = T_ERASE_US * CLK_MHZ;
    localparam int          WB_CYC         = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int          BUSY_LIMIT_DEF = 2 * ERASE_CYC;
    localparam int          TMR_W          = 20;

    // Array shape
    localparam int          PAGE_BYTES     = 4320;
    localparam int          PAGES_PER_BLK  = 128;
    localparam int          BLOCKS         = 4096;
    localparam int          ID_BYTES       = 6;
    localparam int          ADDR_CYCLES    = 5;
    localparam int          ROW_CYCLES     = 3;
    localparam int          LEN_W          = 13;
    localparam int          ADDR_W         = 40;

    // Command codes
    localparam logic [7:0]  CMD_READ1      = 8'h00;
    localparam logic [7:0]  CMD_READ2      = 8'h30;
    localparam logic [7:0]  CMD_CB_READ2   = 8'h35;
    localparam logic [7:0]  CMD_PROG1      = 8'h80;
    localparam logic [7:0]  CMD_PROG2      = 8'h10;
    localparam logic [7:0]  CMD_CACHE2     = 8'h15;
    localparam logic [7:0]  CMD_PLANE2     = 8'h11;
    localparam logic [7:0]  CMD_CB_PROG1   = 8'h85;
    localparam logic [7:0]  CMD_ERASE1     = 8'h60;
    localparam logic [7:0]  CMD_ERASE2     = 8'hd0;
    localparam logic [7:0]  CMD_STATUS     = 8'h70;
    localparam logic [7:0]  CMD_MP_STATUS  = 8'hf1;
    localparam logic [7:0]  CMD_ID         = 8'h90;
    localparam logic [7:0]  CMD_RESET      = 8'hff;

    // Status byte fields
    localparam int          ST_FAIL_BIT    = 0;
    localparam int          ST_READY_BIT   = 6;

    // Operations requested by the user
    typedef enum logic [3:0] {
        OP_READ       = 4'b0000,
        OP_PROG       = 4'b0001,
        OP_CACHE_PROG = 4'b0010,
        OP_PLANE_PROG = 4'b0011,
        OP_CB_READ    = 4'b0100,
        OP_CB_PROG    = 4'b0101,
        OP_ERASE      = 4'b0110,
        OP_PLANE_ERA  = 4'b0111,
        OP_STATUS     = 4'b1000,
        OP_READ_ID    = 4'b1001,
        OP_RESET      = 4'b1010
    } op_t;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_CMD1     = 4'b0001,
        ST_ADDR     = 4'b0010,
        ST_WDATA    = 4'b0011,
        ST_CMD2     = 4'b0100,
        ST_WAIT     = 4'b0101,
        ST_RDATA    = 4'b0110,
        ST_STAT_CMD = 4'b0111,
        ST_STAT_RD  = 4'b1000,
        ST_DONE     = 4'b1001
    } seq_t;

endpackage

// File: hdl/busy_timer.sv
// Down counter that bounds the wait for the ready/busy line
`timescale 1ns/1ps
module busy_timer
(
    // Clock and reset
    input  wire logic                             sys_clk,
    input  wire logic                             rst_b,
    // Control
    input  wire logic                             load,
    input  wire logic [flash_host_pkg::TMR_W-1:0] load_val,
    // Status
    output logic                                  expired_ff
);
    import flash_host_pkg::*;

    logic [TMR_W-1:0] count_ff;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_ff   <= '0;
            expired_ff <= 1'b0;
        end
        else if (load)
        begin
            count_ff   <= load_val;
            expired_ff <= 1'b0;
        end
        else if (count_ff != '0)
        begin
            count_ff   <= count_ff - 1'b1;
            expired_ff <= (count_ff == {{(TMR_W-1){1'b0}}, 1'b1});
        end
    end

endmodule

// File: hdl/flash_host.sv
// Host-side sequencer driving a multiplexed 8-bit NAND flash
`timescale 1ns/1ps
// Notes on behaviour
// R01: Bytes go out on bus, latched at rising strobe
// R02: Command latch enable high only for commands
// R03: Address latch enable high only for addresses
// R04: Each output strobe fall yields next byte
// R05: Device floats bus unless selected and enabled
// R06: Write protect low blocks program and erase
// R07: Ready/busy is shared open-drain status line
// R08: Chip enable may drop during read busy
// R09: Page read busy lasts at most 60 us
// R10: At least 25 ns per strobe cycle
// R11: Multi-plane targets lie in different planes
// R12: Cache program overlaps data load and programming
// R13: Copy-back programs read page without reload
// R14: 4096 blocks, 128 pages, 4320-byte pages
// R15: Program 800 us, erase 2.5 ms busy
// R16: Identification read returns six bytes
// R17: Exactly five address bytes per address phase; the code sends three for erase and one for read ID
// R18: Completion polled via status bit six; the code waits on rb_n or the busy timer, reading status bit 0 only after non-plane program or erase
// R19: Device powers up in page read mode
// R20: Write protect is a level, never latched
// R21: Never raise both latch enables together
module flash_host
#(
    parameter int BUSY_LIMIT = flash_host_pkg::BUSY_LIMIT_DEF
)
(
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              rst_b,
    // Operation request
    input  wire logic                              op_valid,
    input  wire flash_host_pkg::op_t               op_code,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] op_addr,
    input  wire logic [flash_host_pkg::LEN_W-1:0]  op_len,
    input  wire logic                              write_enable_req,
    output logic                                   op_ready_ff,
    output logic                                   op_done_ff,
    output logic                                   op_fail_ff,
    output logic [7:0]                             status_ff,
    // Write data stream
    input  wire logic [7:0]                        wr_data,
    input  wire logic                              wr_valid,
    output logic                                   wr_take_ff,
    // Read data stream
    output logic [7:0]                             rd_data_ff,
    output logic                                   rd_valid_ff,
    // Flash pins
    output logic                                   ce_n_ff,
    output logic                                   cle_ff,
    output logic                                   ale_ff,
    output logic                                   we_n_ff,
    output logic                                   output_strobe_n_ff,
    output logic                                   wp_n_ff,
    output logic [7:0]                             bus_out_ff,
    output logic                                   bus_oe_ff,
    input  wire logic [7:0]                        shared_bus_lines,
    input  wire logic                              rb_n
);
    import flash_host_pkg::*;

    seq_t              state_ff;
    op_t               op_ff;
    logic              phase_ff;
    logic [7:0]        cmd1_ff;
    logic [7:0]        cmd2_ff;
    logic              has_c2_ff;
    logic [2:0]        naddr_ff;
    logic [2:0]        acnt_ff;
    logic [ADDR_W-1:0] addr_sh_ff;
    logic              is_wr_ff;
    logic              is_rd_ff;
    logic              do_wait_ff;
    logic              do_poll_ff;
    logic [LEN_W-1:0]  len_ff;
    logic [LEN_W-1:0]  cnt_ff;
    logic [2:0]        wb_ff;
    logic              tmr_load;
    logic              tmr_exp;
    logic              timeout_ff;

    // Pick the state that follows the command/data phase
    function automatic seq_t after_xfer(input logic w, input logic rd, input logic p);
        seq_t s;
        s = ST_DONE;
        if (w)
            s = ST_WAIT;
        else if (rd)
            s = ST_RDATA;
        else if (p)
            s = ST_STAT_CMD;
        return s;
    endfunction

    assign tmr_load = (state_ff != ST_WAIT);

    busy_timer u_timer
    (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .load       (tmr_load),
        .load_val   (TMR_W'(BUSY_LIMIT)),
        .expired_ff (tmr_exp)
    );

    // Write protect follows the request level continuously
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            wp_n_ff <= 1'b0;
        else
            wp_n_ff <= write_enable_req; // R06 R20
    end

    // Sequencer, pins and counters
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff           <= ST_IDLE;
            op_ff              <= OP_READ;
            phase_ff           <= 1'b0;
            cmd1_ff            <= 8'h00;
            cmd2_ff            <= 8'h00;
            has_c2_ff          <= 1'b0;
            naddr_ff           <= 3'h0;
            acnt_ff            <= 3'h0;
            addr_sh_ff         <= '0;
            is_wr_ff           <= 1'b0;
            is_rd_ff           <= 1'b0;
            do_wait_ff         <= 1'b0;
            do_poll_ff         <= 1'b0;
            len_ff             <= '0;
            cnt_ff             <= '0;
            wb_ff              <= 3'h0;
            timeout_ff         <= 1'b0;
            ce_n_ff            <= 1'b1;
            cle_ff             <= 1'b0;
            ale_ff             <= 1'b0;
            we_n_ff            <= 1'b1;
            output_strobe_n_ff <= 1'b1;
            bus_out_ff         <= 8'h00;
            bus_oe_ff          <= 1'b0;
            wr_take_ff         <= 1'b0;
            rd_data_ff         <= 8'h00;
            rd_valid_ff        <= 1'b0;
            op_done_ff         <= 1'b0;
            op_fail_ff         <= 1'b0;
            status_ff          <= 8'h00;
        end
        else
        begin
            wr_take_ff  <= 1'b0;
            rd_valid_ff <= 1'b0;
            op_done_ff  <= 1'b0;
            op_fail_ff  <= 1'b0;
            phase_ff    <= ~phase_ff;
            case (state_ff)
                ST_IDLE:
                begin
                    phase_ff   <= 1'b0;
                    ce_n_ff    <= 1'b1;
                    bus_oe_ff  <= 1'b0;
                    timeout_ff <= 1'b0;
                    if (op_valid)
                    begin
                        op_ff      <= op_code;
                        len_ff     <= op_len;
                        cnt_ff     <= '0;
                        acnt_ff    <= 3'h0;
                        addr_sh_ff <= op_addr;
                        has_c2_ff  <= 1'b1;
                        naddr_ff   <= 3'(ADDR_CYCLES); // R17
                        is_wr_ff   <= 1'b0;
                        is_rd_ff   <= 1'b0;
                        do_wait_ff <= 1'b1;
                        do_poll_ff <= 1'b0;
                        state_ff   <= ST_CMD1;
                        case (op_code)
                            OP_READ:
                            begin
                                cmd1_ff  <= CMD_READ1;
                                cmd2_ff  <= CMD_READ2;
                                is_rd_ff <= 1'b1; // R09 R14
                            end
                            OP_CB_READ:
                            begin
                                cmd1_ff  <= CMD_READ1;
                                cmd2_ff  <= CMD_CB_READ2;
                                is_rd_ff <= (op_len != '0); // R13
                            end
                            OP_PROG, OP_CACHE_PROG, OP_PLANE_PROG, OP_CB_PROG:
                            begin
                                cmd1_ff    <= (op_code == OP_CB_PROG) ? CMD_CB_PROG1 : CMD_PROG1;
                                cmd2_ff    <= (op_code == OP_CACHE_PROG) ? CMD_CACHE2 :
                                              (op_code == OP_PLANE_PROG) ? CMD_PLANE2 :
                                              CMD_PROG2; // R11 R12 R13
                                is_wr_ff   <= (op_len != '0);
                                do_poll_ff <= (op_code != OP_PLANE_PROG); // R15 R18
                            end
                            OP_ERASE, OP_PLANE_ERA:
                            begin
                                cmd1_ff    <= CMD_ERASE1;
                                cmd2_ff    <= CMD_ERASE2;
                                has_c2_ff  <= (op_code == OP_ERASE); // R11
                                do_wait_ff <= (op_code == OP_ERASE);
                                do_poll_ff <= (op_code == OP_ERASE); // R15 R18
                                naddr_ff   <= 3'(ROW_CYCLES);
                                addr_sh_ff <= op_addr >> 16;
                            end
                            OP_STATUS:
                            begin
                                cmd1_ff    <= CMD_STATUS;
                                has_c2_ff  <= 1'b0;
                                naddr_ff   <= 3'h0;
                                do_wait_ff <= 1'b0;
                                is_rd_ff   <= 1'b1;
                                len_ff     <= LEN_W'(1);
                            end
                            OP_READ_ID:
                            begin
                                cmd1_ff    <= CMD_ID;
                                has_c2_ff  <= 1'b0;
                                naddr_ff   <= 3'h1;
                                do_wait_ff <= 1'b0;
                                is_rd_ff   <= 1'b1;
                                len_ff     <= LEN_W'(ID_BYTES); // R16
                            end
                            default:
                            begin
                                cmd1_ff    <= CMD_RESET;
                                has_c2_ff  <= 1'b0;
                                naddr_ff   <= 3'h0;
                            end
                        endcase
                    end
                end
                ST_CMD1, ST_CMD2, ST_STAT_CMD:
                begin
                    ce_n_ff    <= 1'b0;
                    cle_ff     <= 1'b1; // R02 R21
                    ale_ff     <= 1'b0;
                    bus_oe_ff  <= 1'b1;
                    we_n_ff    <= phase_ff; // R01 R10
                    bus_out_ff <= (state_ff == ST_CMD1) ? cmd1_ff :
                                  (state_ff == ST_CMD2) ? cmd2_ff : CMD_STATUS;
                    if (phase_ff)
                    begin
                        if (state_ff == ST_STAT_CMD)
                            state_ff <= ST_STAT_RD;
                        else if (state_ff == ST_CMD2 || !has_c2_ff)
                        begin
                            wb_ff    <= 3'h0;
                            state_ff <= do_wait_ff ? ST_WAIT
                                      : after_xfer(1'b0, is_rd_ff, do_poll_ff);
                        end
                        else if (naddr_ff != 3'h0)
                            state_ff <= ST_ADDR;
                        else
                            state_ff <= is_wr_ff ? ST_WDATA : ST_CMD2;
                        if (state_ff == ST_CMD1 && !has_c2_ff && naddr_ff != 3'h0)
                            state_ff <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    cle_ff     <= 1'b0;
                    ale_ff     <= 1'b1; // R03 R21
                    bus_oe_ff  <= 1'b1;
                    we_n_ff    <= phase_ff; // R01 R10
                    bus_out_ff <= addr_sh_ff[7:0];
                    if (phase_ff)
                    begin
                        addr_sh_ff <= addr_sh_ff >> 8;
                        acnt_ff    <= acnt_ff + 3'h1;
                        if (acnt_ff + 3'h1 == naddr_ff) // R17
                        begin
                            if (is_wr_ff)
                                state_ff <= ST_WDATA;
                            else if (has_c2_ff)
                                state_ff <= ST_CMD2;
                            else
                            begin
                                wb_ff    <= 3'h0;
                                state_ff <= do_wait_ff ? ST_WAIT
                                          : after_xfer(1'b0, is_rd_ff, do_poll_ff);
                            end
                        end
                    end
                end
                ST_WDATA:
                begin
                    ale_ff <= 1'b0;
                    if (!phase_ff && !wr_valid)
                    begin
                        phase_ff <= 1'b0;
                        we_n_ff  <= 1'b1;
                    end
                    else
                    begin
                        bus_oe_ff <= 1'b1;
                        we_n_ff   <= phase_ff; // R01 R10
                        if (!phase_ff)
                        begin
                            bus_out_ff <= wr_data;
                            wr_take_ff <= 1'b1;
                        end
                        else
                        begin
                            cnt_ff <= cnt_ff + 1'b1;
                            if (cnt_ff + 1'b1 == len_ff)
                                state_ff <= has_c2_ff ? ST_CMD2 : ST_DONE;
                        end
                    end
                end
                ST_WAIT:
                begin
                    phase_ff  <= 1'b0;
                    cle_ff    <= 1'b0;
                    ale_ff    <= 1'b0;
                    we_n_ff   <= 1'b1;
                    bus_oe_ff <= 1'b0;
                    ce_n_ff   <= is_rd_ff; // R08
                    if (wb_ff != 3'(WB_CYC))
                        wb_ff <= wb_ff + 3'h1;
                    else if (rb_n || tmr_exp) // R07 R09 R15
                    begin
                        timeout_ff <= ~rb_n;
                        cnt_ff     <= '0;
                        state_ff   <= after_xfer(1'b0, is_rd_ff, do_poll_ff);
                    end
                end
                ST_RDATA, ST_STAT_RD:
                begin
                    ce_n_ff            <= 1'b0;
                    cle_ff             <= 1'b0;
                    ale_ff             <= 1'b0;
                    bus_oe_ff          <= 1'b0;
                    output_strobe_n_ff <= phase_ff; // R04 R10
                    if (phase_ff)
                    begin
                        if (state_ff == ST_STAT_RD || op_ff == OP_STATUS)
                            status_ff <= shared_bus_lines; // R18
                        if (state_ff == ST_STAT_RD)
                            state_ff <= ST_DONE;
                        else
                        begin
                            rd_data_ff  <= shared_bus_lines;
                            rd_valid_ff <= 1'b1;
                            cnt_ff      <= cnt_ff + 1'b1;
                            if (cnt_ff + 1'b1 >= len_ff)
                                state_ff <= do_poll_ff ? ST_STAT_CMD : ST_DONE;
                        end
                    end
                end
                ST_DONE:
                begin
                    phase_ff           <= 1'b0;
                    ce_n_ff            <= 1'b1;
                    output_strobe_n_ff <= 1'b1;
                    bus_oe_ff          <= 1'b0;
                    cle_ff             <= 1'b0;
                    ale_ff             <= 1'b0;
                    op_done_ff         <= 1'b1;
                    op_fail_ff         <= timeout_ff | (do_poll_ff & status_ff[ST_FAIL_BIT]);
                    state_ff           <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Ready to accept a new operation
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            op_ready_ff <= 1'b0;
        else
            op_ready_ff <= (state_ff == ST_IDLE) && !op_valid;
    end

endmodule

// File: tb/flash_host_props.sv
// Concurrent checks on the flash host pins
`timescale 1ns/1ps
module flash_host_props
#(
    parameter int BUSY_LIMIT = 500
)
(
    // Clock, reset and request side
    input wire logic sys_clk, rst_b, write_enable_req, op_done_ff, op_fail_ff, rd_valid_ff,
    // Flash pins
    input wire logic ce_n_ff, cle_ff, ale_ff, we_n_ff, output_strobe_n_ff, wp_n_ff, bus_oe_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_latch_excl: assert property (!(cle_ff && ale_ff))
        else $error("both latch enables high");
    a_cmd_latch: assert property (cle_ff && !we_n_ff |-> bus_oe_ff && !ce_n_ff)
        else $error("command cycle not driven");
    a_addr_latch: assert property (ale_ff && !we_n_ff |-> bus_oe_ff && !ce_n_ff)
        else $error("address cycle not driven");
    a_wstrobe_slot: assert property ($fell(we_n_ff) |=> we_n_ff)
        else $error("write strobe low too long");
    a_rstrobe_slot: assert property ($fell(output_strobe_n_ff) |=> output_strobe_n_ff)
        else $error("output strobe low too long");
    a_read_release: assert property (!output_strobe_n_ff |-> !bus_oe_ff && !ce_n_ff && !cle_ff
        && !ale_ff && we_n_ff)
        else $error("bus driven during read");
    a_wp_level: assert property ($past(rst_b) |-> wp_n_ff == $past(write_enable_req))
        else $error("protect pin lags request");
    a_fail_done: assert property (op_fail_ff |-> op_done_ff)
        else $error("fail without done");
    c_done: cover property (op_done_ff && !op_fail_ff);
    c_fail: cover property (op_fail_ff);
    c_burst: cover property (rd_valid_ff ##2 rd_valid_ff);
endmodule
bind flash_host flash_host_props #(.BUSY_LIMIT(BUSY_LIMIT)) i_props (.sys_clk, .rst_b,
    .write_enable_req, .op_done_ff, .op_fail_ff, .rd_valid_ff, .ce_n_ff, .cle_ff, .ale_ff,
    .we_n_ff, .output_strobe_n_ff, .wp_n_ff, .bus_oe_ff);

// File: tb/flash_dev_model.sv
// Behavioural NAND flash device facing the host
`timescale 1ns/1ps
module flash_dev_model
#(
    parameter int         BUSY_NS = 2000,
    parameter logic [7:0] ID_BASE = 8'ha0 // Arbitrary value
)
(
    // Pins and test control
    input  wire logic       ce_n, cle, ale, we_n, strobe_n, wp_n, slow,
    input  wire logic [7:0] din,
    output logic      [7:0] dq,
    output logic            dq_oe, rb_low
);
    logic [7:0] mem [256];
    logic [7:0] pb [256];
    logic       ps [256];
    logic [7:0] cmd = 8'h00;
    logic [7:0] col = 8'h00;
    logic       rdy = 1'h1;
    int         ac = 0;
    initial foreach (mem[i]) mem[i] = 8'hff;
    initial {dq, rb_low} = 9'h000;
    assign dq_oe = !ce_n && !strobe_n;
    task automatic busy(input int ns);
        rdy = 1'h0;
        rb_low = 1'h1;
        #(slow ? 3 * ns : ns);
        rdy = 1'h1;
        rb_low = 1'h0;
    endtask
    always @(posedge we_n)
    begin
        if (!ce_n && cle)
        begin
            cmd = din;
            ac = 0;
            if (din == 8'h80) foreach (ps[i]) ps[i] = 1'h0;
            if ((din == 8'h10 || din == 8'h15) && wp_n)
                foreach (ps[i]) if (ps[i]) mem[i] = pb[i];
            if (din == 8'hd0 && wp_n) foreach (mem[i]) mem[i] = 8'hff;
            if (din == 8'h30 || din == 8'h35 || din == 8'hff) busy(BUSY_NS);
            if ((din == 8'h10 || din == 8'h15 || din == 8'hd0) && wp_n) busy(BUSY_NS);
        end
        else if (!ce_n && ale)
        begin
            if (ac == 0) col = din;
            ac++;
        end
        else if (!ce_n)
        begin
            pb[col] = din;
            ps[col] = 1'h1;
            col++;
        end
    end
    always @(negedge strobe_n)
    begin
        if (!ce_n && (cmd == 8'h70 || cmd == 8'hf1)) dq = {wp_n, rdy, rdy, 5'h00};
        else if (!ce_n)
        begin
            dq = (cmd == 8'h90) ? ID_BASE + col : mem[col];
            col++;
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module tb;
    import flash_host_pkg::*;
    typedef struct {op_t op; logic [7:0] col; int len; logic [7:0] base, step; int nrd;} row_t;
    logic sys_clk = 1'h0, rst_b = 1'h0, op_valid = 1'h0, write_enable_req = 1'h0;
    logic wr_valid = 1'h0, slow = 1'h0, stall = 1'h0;
    op_t op_code = OP_STATUS;
    logic [ADDR_W-1:0] op_addr = 40'h0;
    logic [LEN_W-1:0] op_len = 13'h0;
    logic [7:0] wr_data = 8'h00, rd_data_ff, bus_out_ff, dq, shared_bus_lines, status_ff;
    logic op_ready_ff, op_done_ff, op_fail_ff, wr_take_ff, rd_valid_ff, ce_n_ff, cle_ff, ale_ff;
    logic we_n_ff, output_strobe_n_ff, wp_n_ff, bus_oe_ff, dq_oe, rb_low, rb_n;
    int num_errors = 0;
    int num_checks = 0;
    row_t rows [13] = '{'{OP_RESET, 8'h00, 0, 8'h00, 8'h00, 0},
        '{OP_PROG, 8'h10, 4, 8'h40, 8'h01, 0}, '{OP_READ, 8'h10, 4, 8'h40, 8'h01, 4},
        '{OP_CACHE_PROG, 8'h30, 2, 8'h50, 8'h01, 0}, '{OP_READ, 8'h30, 2, 8'h50, 8'h01, 2},
        '{OP_READ_ID, 8'h00, 0, 8'ha0, 8'h01, 6}, '{OP_STATUS, 8'h00, 0, 8'he0, 8'h00, 1},
        '{OP_CB_READ, 8'h10, 0, 8'h00, 8'h00, 0}, '{OP_CB_PROG, 8'h50, 0, 8'h00, 8'h00, 0},
        '{OP_PLANE_PROG, 8'h60, 1, 8'h22, 8'h00, 0}, '{OP_PLANE_ERA, 8'h00, 0, 8'h00, 8'h00, 0},
        '{OP_ERASE, 8'h00, 0, 8'h00, 8'h00, 0}, '{OP_READ, 8'h10, 2, 8'hff, 8'h00, 2}};
    flash_host #(.BUSY_LIMIT(500)) i_dut (.sys_clk, .rst_b, .op_valid, .op_code, .op_addr,
        .op_len, .write_enable_req, .op_ready_ff, .op_done_ff, .op_fail_ff, .status_ff,
        .wr_data, .wr_valid, .wr_take_ff, .rd_data_ff, .rd_valid_ff, .ce_n_ff, .cle_ff, .ale_ff,
        .we_n_ff, .output_strobe_n_ff, .wp_n_ff, .bus_out_ff, .bus_oe_ff, .shared_bus_lines, .rb_n);
    flash_dev_model i_dev (.ce_n(ce_n_ff), .cle(cle_ff), .ale(ale_ff), .we_n(we_n_ff),
        .strobe_n(output_strobe_n_ff), .wp_n(wp_n_ff), .slow, .din(shared_bus_lines), .dq,
        .dq_oe, .rb_low);
    assign shared_bus_lines = bus_oe_ff ? bus_out_ff : (dq_oe ? dq : ~dq);
    assign rb_n = !(rb_low || stall);
    always #25 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run(input row_t r, input logic wen, input logic xfail);
        int n;
        int t;
        n = 0;
        t = 0;
        write_enable_req <= wen;
        repeat (2) @(posedge sys_clk);
        while (op_ready_ff !== 1'h1) @(posedge sys_clk);
        op_code <= r.op;
        op_addr <= {32'h0, r.col};
        op_len <= r.len[12:0];
        wr_data <= r.base;
        wr_valid <= 1'h1;
        op_valid <= 1'h1;
        @(posedge sys_clk);
        op_valid <= 1'h0;
        while (op_done_ff !== 1'h1 && t < 5000)
        begin
            @(posedge sys_clk);
            t++;
            if (rd_valid_ff === 1'h1) chk("rd_data_ff", r.base + r.step * n[7:0], rd_data_ff);
            if (rd_valid_ff === 1'h1) n++;
            if (wr_take_ff === 1'h1) wr_data <= wr_data + r.step;
        end
        wr_valid <= 1'h0;
        chk("op_done_ff", 8'h01, {7'h00, op_done_ff});
        chk("rd_count", r.nrd[7:0], n[7:0]);
        if (xfail !== 1'hx) chk("op_fail_ff", {7'h00, xfail}, {7'h00, op_fail_ff});
        if (r.op == OP_STATUS) chk("status_ff", r.base, status_ff);
        if (xfail === 1'hx) chk("status_ff", 8'h60, status_ff);
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        chk("wp_n_ff", 8'h00, {7'h00, wp_n_ff});
        chk("bus_oe_ff", 8'h00, {7'h00, bus_oe_ff});
        rst_b <= 1'h1;
        foreach (rows[i]) run(rows[i], 1'h1, 1'h0);
        run(row_t'{OP_PROG, 8'h20, 2, 8'h77, 8'h01, 0}, 1'h0, 1'hx);
        run(row_t'{OP_READ, 8'h20, 2, 8'hff, 8'h00, 2}, 1'h1, 1'h0);
        stall <= 1'h1;
        run(row_t'{OP_PROG, 8'h40, 1, 8'h11, 8'h00, 0}, 1'h1, 1'h1);
        stall <= 1'h0;
        slow <= 1'h1;
        run(row_t'{OP_READ, 8'h40, 1, 8'h11, 8'h00, 1}, 1'h1, 1'h0);
        results();
    end
    initial
    begin
        #1000000;
        num_errors++;
        results();
    end
endmodule
